// ===== core/lcdd_pkg.sv
// package for the character display instruction decoder
// holds timing counts, instruction bit positions, reset values and encodings
// assumes a 10 MHz core clock feeding the decoder
package lcdd_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 100;      // core clock period
  localparam int EXEC_SHORT_US = 53;       // ordinary instruction execution time
  localparam int EXEC_LONG_US = 2160;      // clear / return-home execution time
  // round down: busy must be gone inside the longest allowed time
  localparam int SHORT_CYCLES = (EXEC_SHORT_US * 1000) / CLK_PERIOD_NS;
  localparam int LONG_CYCLES_DEF = (EXEC_LONG_US * 1000) / CLK_PERIOD_NS;
  localparam int CNT_W = 15;               // busy counter width, holds LONG_CYCLES_DEF

  // ************************************************************
  // memory layout
  // ************************************************************
  localparam int MEM_AW = 8;               // text half at top, glyph half at bottom
  localparam logic [MEM_AW-1:0] FILL_LAST = 8'hFF; // last text location to blank
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [6:0] HOME_ADDR = 7'h00;

  // ************************************************************
  // instruction bit positions
  // ************************************************************
  localparam int BIT_ADV_INC = 1;          // entry: advance direction
  localparam int BIT_ADV_SHIFT = 0;        // entry: whole-display shift
  localparam int BIT_DISP_ON = 2;          // control: display on
  localparam int BIT_CUR_ON = 1;           // control: cursor visible
  localparam int BIT_BLINK = 0;            // control: cursor blink
  localparam int BIT_SHIFT_DISP = 3;       // shift: display rather than cursor
  localparam int BIT_SHIFT_RIGHT = 2;      // shift: direction
  localparam int BIT_BUS_WIDTH = 4;        // function: 8-bit when set
  localparam int BIT_TWO_LINES = 3;        // function: two lines when set
  localparam int BIT_TALL_FONT = 2;        // function: 5x10 glyph when set

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic RST_ADV_INC = 1'b1;
  localparam logic RST_ADV_SHIFT = 1'b0;
  localparam logic RST_DISP_ON = 1'b0;
  localparam logic RST_CUR_ON = 1'b0;
  localparam logic RST_BLINK = 1'b0;
  localparam logic RST_BUS_WIDTH = 1'b1;
  localparam logic RST_TWO_LINES = 1'b0;
  localparam logic RST_TALL_FONT = 1'b0;

  // ************************************************************
  // encodings
  // ************************************************************
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0, CMD_CLEAR = 4'h1, CMD_HOME = 4'h2, CMD_ENTRY = 4'h3,
    CMD_CONTROL = 4'h4, CMD_SHIFT = 4'h5, CMD_FUNCTION = 4'h6,
    CMD_GLYPH_ADDR = 4'h7, CMD_TEXT_ADDR = 4'h8
  } lcdd_cmd_t;

  // gray along idle -> wait -> idle and fill -> wait; idle -> fill is rare
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_WAIT = 2'b01, ST_FILL = 2'b11
  } lcdd_state_t;

endpackage : lcdd_pkg

// ===== core/lcdd_mem.sv
// small memory holding display text and glyph patterns
// assumes a single clock; read data registered, no reset on the array
`timescale 1ns/1ps
`default_nettype none
module lcdd_mem
  import lcdd_pkg::*;
(
  // clock
  input wire logic clock,
  // access port
  input wire logic wr_en,
  input wire logic [MEM_AW-1:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data
);

  logic [7:0] store [0:(1<<MEM_AW)-1]; // bytes, text and glyph halves

  // ************************************************************
  // write and registered read
  // ************************************************************
  // read-before-write: rd_data shows the old byte on a write cycle
  always_ff @(posedge clock) begin
    if (wr_en) begin
      store[addr] <= wr_data;
    end
    rd_data <= store[addr];
  end

endmodule : lcdd_mem
`default_nettype wire

// ===== core/lcdd_top.sv
// character display instruction decoder and host port
// assumes the host pins are asynchronous to clock and are synchronised here
`timescale 1ns/1ps
`default_nettype none
module lcdd_top
  import lcdd_pkg::*;
#(
  parameter int LONG_CYCLES = LONG_CYCLES_DEF // long busy time, shorten for simulation
)
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // host pins
  input wire logic target_select,
  input wire logic read_mode,
  input wire logic strobe,
  input wire logic [7:0] host_data_lines_in,
  output logic [7:0] host_data_lines_out,
  output logic host_data_lines_oe,
  // decoder state
  output logic busy_indicator,
  output logic display_on,
  output logic cursor_on,
  output logic blink_on,
  output logic bus_width,
  output logic two_lines,
  output logic tall_font,
  output logic [6:0] shift_offset
);

  // ************************************************************
  // reset release
  // ************************************************************
  logic rst_q1; // first release stage
  logic rst_n; // released reset used everywhere else

  // reset asserts at once and releases after two edges
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [10:0] pin_q1; // first stage, read only by the second
  logic [10:0] pin_q2; // settled pin levels
  logic strobe_d; // previous settled strobe, for edges
  logic sel_s; // settled select
  logic rd_s; // settled direction
  logic strobe_s; // settled strobe
  logic [7:0] data_s; // settled data lines

  // two flops on every host pin before any logic looks at it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_q1 <= 11'h000;
      pin_q2 <= 11'h000;
      strobe_d <= 1'b0;
    end else begin
      pin_q1 <= {target_select, read_mode, strobe, host_data_lines_in};
      pin_q2 <= pin_q1;
      strobe_d <= pin_q2[8];
    end
  end

  assign sel_s = pin_q2[10];
  assign rd_s = pin_q2[9];
  assign strobe_s = pin_q2[8];
  assign data_s = pin_q2[7:0];

  logic strobe_rise; // strobe went high
  logic strobe_fall; // strobe went low
  assign strobe_rise = strobe_s & ~strobe_d;
  assign strobe_fall = ~strobe_s & strobe_d;

  // ************************************************************
  // capture while strobe high
  // ************************************************************
  logic cap_sel; // select seen during the strobe
  logic cap_rd; // direction seen during the strobe
  logic [7:0] cap_data; // data seen during the strobe

  // keep the last levels from the high phase so the hold time after
  // the fall is not needed inside the synchroniser delay
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cap_sel <= 1'b0;
      cap_rd <= 1'b0;
      cap_data <= 8'h00;
    end else if (strobe_s) begin
      cap_sel <= sel_s;
      cap_rd <= rd_s;
      cap_data <= data_s;
    end
  end

  // ************************************************************
  // nibble pairing
  // ************************************************************
  logic low_phase; // next transfer carries the low nibble
  logic [3:0] high_nib; // high nibble held from the first transfer
  logic byte_done; // this fall completes a whole byte
  logic [7:0] full_byte; // assembled byte for this fall
  logic width_change; // function set is changing the bus width

  assign byte_done = strobe_fall & (bus_width | low_phase);
  assign full_byte = bus_width ? cap_data : {high_nib, cap_data[7:4]};

  // in four-bit mode every transfer, read or write, flips the phase
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      low_phase <= 1'b0;
      high_nib <= 4'h0;
    end else if (width_change) begin
      low_phase <= 1'b0; // a new width always starts on a high nibble
    end else if (strobe_fall && !bus_width) begin
      low_phase <= ~low_phase;
      if (!low_phase) begin
        high_nib <= cap_data[7:4];
      end
    end
  end

  // ************************************************************
  // instruction decode
  // ************************************************************
  // the highest set bit names the instruction
  function automatic lcdd_cmd_t decode_cmd(input logic [7:0] code);
    lcdd_cmd_t c;
    c = CMD_NONE;
    if (code[7]) c = CMD_TEXT_ADDR;
    else if (code[6]) c = CMD_GLYPH_ADDR;
    else if (code[5]) c = CMD_FUNCTION;
    else if (code[4]) c = CMD_SHIFT;
    else if (code[3]) c = CMD_CONTROL;
    else if (code[2]) c = CMD_ENTRY;
    else if (code[1]) c = CMD_HOME;
    else if (code[0]) c = CMD_CLEAR;
    return c;
  endfunction : decode_cmd

  lcdd_state_t state; // execution state
  logic go; // a whole byte, write or read, is accepted this cycle
  logic instr_go; // an instruction write is accepted
  logic data_wr_go; // a data write is accepted
  logic data_rd_go; // a data read has completed
  lcdd_cmd_t cmd; // decoded instruction

  // while busy, writes and data reads are dropped; status reads still work
  assign go = byte_done & ~busy_indicator;
  assign instr_go = go & ~cap_rd & ~cap_sel;
  assign data_wr_go = go & ~cap_rd & cap_sel;
  assign data_rd_go = go & cap_rd & cap_sel;
  assign cmd = instr_go ? decode_cmd(full_byte) : CMD_NONE;
  assign width_change = (cmd == CMD_FUNCTION) && (full_byte[BIT_BUS_WIDTH] != bus_width);

  // ************************************************************
  // mode flags
  // ************************************************************
  logic adv_inc; // position steps up after data access
  logic adv_shift; // display shifts with each text data write

  // flag registers loaded by their own instruction
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      adv_inc <= RST_ADV_INC;
      adv_shift <= RST_ADV_SHIFT;
      display_on <= RST_DISP_ON;
      cursor_on <= RST_CUR_ON;
      blink_on <= RST_BLINK;
      bus_width <= RST_BUS_WIDTH;
      two_lines <= RST_TWO_LINES;
      tall_font <= RST_TALL_FONT;
    end else begin
      unique case (cmd)
        CMD_ENTRY: begin
          adv_inc <= full_byte[BIT_ADV_INC];
          adv_shift <= full_byte[BIT_ADV_SHIFT];
        end
        CMD_CONTROL: begin
          display_on <= full_byte[BIT_DISP_ON];
          cursor_on <= full_byte[BIT_CUR_ON];
          blink_on <= full_byte[BIT_BLINK];
        end
        CMD_FUNCTION: begin
          bus_width <= full_byte[BIT_BUS_WIDTH];
          two_lines <= full_byte[BIT_TWO_LINES];
          tall_font <= full_byte[BIT_TALL_FONT];
        end
        default: begin
          // other instructions leave the flags alone
        end
      endcase
    end
  end

  // ************************************************************
  // position counter, memory select and display shift
  // ************************************************************
  logic [6:0] position_counter; // current memory position
  logic glyph_sel; // data accesses go to glyph memory
  logic [6:0] pos_step; // position after one step

  // glyph memory wraps in six bits, text memory in seven
  always_comb begin
    pos_step = adv_inc ? position_counter + 7'd1 : position_counter - 7'd1;
    if (glyph_sel) begin
      pos_step[6] = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      position_counter <= HOME_ADDR;
      glyph_sel <= 1'b0;
      shift_offset <= 7'h00;
    end else begin
      unique case (cmd)
        CMD_CLEAR: begin
          position_counter <= HOME_ADDR;
          glyph_sel <= 1'b0;
        end
        CMD_HOME: begin
          position_counter <= HOME_ADDR;
          glyph_sel <= 1'b0;
          shift_offset <= 7'h00;
        end
        CMD_SHIFT: begin
          // only the counter or the offset moves, memory is untouched
          if (full_byte[BIT_SHIFT_DISP]) begin
            shift_offset <= full_byte[BIT_SHIFT_RIGHT] ? shift_offset + 7'd1
                                                       : shift_offset - 7'd1;
          end else begin
            position_counter <= full_byte[BIT_SHIFT_RIGHT] ? position_counter + 7'd1
                                                           : position_counter - 7'd1;
          end
        end
        CMD_GLYPH_ADDR: begin
          position_counter <= {1'b0, full_byte[5:0]};
          glyph_sel <= 1'b1;
        end
        CMD_TEXT_ADDR: begin
          position_counter <= full_byte[6:0];
          glyph_sel <= 1'b0;
        end
        default: begin
          if (data_wr_go || data_rd_go) begin
            position_counter <= pos_step;
          end
          if (data_wr_go && adv_shift && !glyph_sel) begin
            shift_offset <= adv_inc ? shift_offset + 7'd1 : shift_offset - 7'd1;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // busy sequencing
  // ************************************************************
  logic [CNT_W-1:0] wait_cnt; // cycles left of the current execution
  logic [MEM_AW-1:0] fill_addr; // text location being blanked
  logic [CNT_W-1:0] long_cnt; // long time at counter width
  logic [CNT_W-1:0] short_cnt; // short time at counter width

  assign long_cnt = CNT_W'(LONG_CYCLES - 1);
  assign short_cnt = CNT_W'(SHORT_CYCLES - 1);

  // reset lands in the fill state: the automatic start-up blanks the
  // text and holds busy for the long time with no host help
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_FILL;
      busy_indicator <= 1'b1;
      wait_cnt <= CNT_W'(LONG_CYCLES - 1);
      fill_addr <= {1'b1, HOME_ADDR};
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (cmd == CMD_CLEAR) begin
            state <= ST_FILL;
            busy_indicator <= 1'b1;
            wait_cnt <= long_cnt;
            fill_addr <= {1'b1, HOME_ADDR};
          end else if (cmd == CMD_HOME) begin
            state <= ST_WAIT;
            busy_indicator <= 1'b1;
            wait_cnt <= long_cnt;
          end else if (instr_go || data_wr_go || data_rd_go) begin
            state <= ST_WAIT;
            busy_indicator <= 1'b1;
            wait_cnt <= short_cnt;
          end
        end
        ST_FILL: begin
          // one text location per cycle, far shorter than the long time
          wait_cnt <= wait_cnt - CNT_W'(1);
          fill_addr <= fill_addr + MEM_AW'(1);
          if (fill_addr == FILL_LAST) begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (wait_cnt == '0) begin
            state <= ST_IDLE;
            busy_indicator <= 1'b0;
          end else begin
            wait_cnt <= wait_cnt - CNT_W'(1);
          end
        end
        default: begin
          state <= ST_IDLE;
          busy_indicator <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // memory access
  // ************************************************************
  logic mem_we; // write strobe to the store
  logic [MEM_AW-1:0] mem_addr; // store address
  logic [7:0] mem_wdata; // store write byte
  logic [7:0] mem_rdata; // registered read byte

  // fill owns the port while blanking; otherwise the position does
  always_comb begin
    if (state == ST_FILL) begin
      mem_we = 1'b1;
      mem_addr = fill_addr;
      mem_wdata = SPACE_CODE;
    end else begin
      mem_we = data_wr_go;
      mem_addr = glyph_sel ? {2'b00, position_counter[5:0]} : {1'b1, position_counter};
      mem_wdata = full_byte;
    end
  end

  lcdd_mem u_mem (
    .clock(clock),
    .wr_en(mem_we),
    .addr(mem_addr),
    .wr_data(mem_wdata),
    .rd_data(mem_rdata)
  );

  // ************************************************************
  // read path
  // ************************************************************
  logic [7:0] rd_byte; // byte being returned, held for the low nibble
  logic [7:0] rd_pick; // byte chosen at this rise

  // select high reads memory, low reads busy and position
  assign rd_pick = sel_s ? mem_rdata : {busy_indicator, position_counter};

  // the pins are driven only while the strobe stays high in read mode
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_byte <= 8'h00;
      host_data_lines_out <= 8'h00;
      host_data_lines_oe <= 1'b0;
    end else begin
      host_data_lines_oe <= strobe_s & rd_s;
      if (strobe_rise && rd_s) begin
        if (bus_width) begin
          rd_byte <= rd_pick;
          host_data_lines_out <= rd_pick;
        end else if (!low_phase) begin
          rd_byte <= rd_pick;
          host_data_lines_out <= {rd_pick[7:4], 4'h0};
        end else begin
          host_data_lines_out <= {rd_byte[3:0], 4'h0};
        end
      end
    end
  end

endmodule : lcdd_top
`default_nettype wire

// ===== bench/lcdd_assertions.sv
// checker for the display decoder host pins and busy timing
// assumes it is bound to lcdd_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module lcdd_checker
  import lcdd_pkg::*;
#(
  parameter int LONG_CYCLES = LONG_CYCLES_DEF // must match the bound instance
)
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // host pins
  input wire logic target_select,
  input wire logic read_mode,
  input wire logic strobe,
  input wire logic [7:0] host_data_lines_out,
  input wire logic host_data_lines_oe,
  // decoder state
  input wire logic busy_indicator,
  input wire logic display_on,
  input wire logic cursor_on,
  input wire logic blink_on,
  input wire logic bus_width,
  input wire logic two_lines,
  input wire logic tall_font,
  input wire logic [6:0] shift_offset
);
  // any busy stretch must end inside the larger of 1000 clocks and the long count plus 8
  localparam int BUSY_MAX = (LONG_CYCLES + 8 > 1000) ? LONG_CYCLES + 8 : 1000;
  logic [15:0] busy_cnt; // length of the current busy stretch
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // ************************************************************
  // busy length counter
  // ************************************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      busy_cnt <= 16'h0000;
    end else if (busy_indicator) begin
      busy_cnt <= busy_cnt + 16'h0001;
    end else begin
      busy_cnt <= 16'h0000;
    end
  end
  // ************************************************************
  // assertions
  // ************************************************************
  oe_source_a: assert property ($rose(host_data_lines_oe) |->
    $past(strobe, 3) && $past(read_mode, 3)) else $error("drive without read strobe");
  oe_release_a: assert property (!strobe [*5] |-> !host_data_lines_oe)
    else $error("bus still driven after strobe fall");
  write_quiet_a: assert property (!read_mode [*5] |-> !host_data_lines_oe)
    else $error("bus driven during write");
  busy_bound_a: assert property (busy_cnt <= BUSY_MAX)
    else $error("busy too long");
  busy_start_a: assert property ($fell(strobe) && !busy_indicator && bus_width &&
    (!read_mode || target_select) |-> ##[2:6] busy_indicator) else $error("busy missing");
  status_bit_a: assert property ($rose(host_data_lines_oe) && !target_select &&
    bus_width && $past(busy_indicator, 1) == $past(busy_indicator, 2)
    |-> host_data_lines_out[7] == $past(busy_indicator, 1)) else $error("status busy bit");
  flags_cause_a: assert property ($changed({display_on, cursor_on, blink_on,
    two_lines, tall_font, shift_offset}) |-> ##[0:2] $rose(busy_indicator))
    else $error("flag change without instruction");
  nibble_pad_a: assert property (host_data_lines_oe && !bus_width |->
    host_data_lines_out[3:0] == 4'h0) else $error("low nibble not zero");
  // main scenarios seen
  cover property ($rose(host_data_lines_oe) && !target_select);
  cover property ($rose(busy_indicator) && target_select && !read_mode);
  cover property ($rose(host_data_lines_oe) && !bus_width);
endmodule : lcdd_checker
bind lcdd_top lcdd_checker #(.LONG_CYCLES(LONG_CYCLES)) chk (.clock(clock), .resetn(resetn),
  .target_select(target_select), .read_mode(read_mode), .strobe(strobe),
  .host_data_lines_out(host_data_lines_out), .host_data_lines_oe(host_data_lines_oe),
  .busy_indicator(busy_indicator), .display_on(display_on), .cursor_on(cursor_on),
  .blink_on(blink_on), .bus_width(bus_width), .two_lines(two_lines),
  .tall_font(tall_font), .shift_offset(shift_offset));
`default_nettype wire

// ===== bench/lcdd_host.sv
// host processor model driving the display pins
// assumes the bench calls its tasks; pins move just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module lcdd_host (
  // clock
  input wire logic clock,
  // pins toward the device
  output logic target_select,
  output logic read_mode,
  output logic strobe,
  output logic [7:0] host_data_lines_in,
  // read answer
  input wire logic [7:0] host_data_lines_out
);
  logic nibble_mode = 1'b0; // set by the bench once four-bit width is programmed
  // ************************************************************
  // pin idle levels
  // ************************************************************
  initial begin
    target_select = 1'b0;
    read_mode = 1'b1;
    strobe = 1'b0;
    host_data_lines_in = 8'hFF;
  end
  // one strobe, 5 clocks high and 5 low, well above the 3 clock minimum
  task automatic access(input logic sel, input logic rd, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge clock);
    target_select <= sel;
    read_mode <= rd;
    host_data_lines_in <= d;
    strobe <= 1'b1;
    repeat (5) @(posedge clock);
    q = host_data_lines_out;
    strobe <= 1'b0;
    @(posedge clock);
    host_data_lines_in <= ~d; // released lines do not keep the old value
    repeat (4) @(posedge clock);
  endtask : access
  // a byte as one strobe, or two with the high nibble first
  task automatic byte_io(input logic sel, input logic rd, input logic [7:0] d,
                         output logic [7:0] q);
    logic [7:0] hi;
    logic [7:0] lo;
    if (nibble_mode) begin
      access(sel, rd, {d[7:4], 4'h0}, hi);
      access(sel, rd, {d[3:0], 4'h0}, lo);
      q = {hi[7:4], lo[7:4]};
    end else begin
      access(sel, rd, d, q);
    end
  endtask : byte_io
  // poll busy before each access, bounded so a stuck device cannot hang us
  task automatic xfer(input logic sel, input logic rd, input logic [7:0] d,
                      output logic [7:0] q);
    logic [7:0] st;
    int n;
    n = 0;
    st = 8'h80;
    while (st[7] !== 1'b0 && n < 200) begin
      byte_io(1'b0, 1'b1, 8'h00, st);
      n++;
    end
    byte_io(sel, rd, d, q);
  endtask : xfer
endmodule : lcdd_host
`default_nettype wire

// ===== bench/tb_char_lcd_instruction_decoder.sv
// self-checking bench for the display instruction decoder
// assumes lcdd_top, lcdd_host and the bound checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module tb_char_lcd_instruction_decoder;
  import lcdd_pkg::*;
  localparam int LONG_SIM = 300; // shortened clear/home time
  logic clock;
  logic resetn;
  logic target_select;
  logic read_mode;
  logic strobe;
  logic [7:0] din;
  logic [7:0] dout;
  logic busy;
  logic disp, cur, blk, bus_w, two_l, tall;
  logic [6:0] shift;
  logic [7:0] q;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  lcdd_top #(.LONG_CYCLES(LONG_SIM)) uut (.clock(clock), .resetn(resetn),
    .target_select(target_select), .read_mode(read_mode), .strobe(strobe),
    .host_data_lines_in(din), .host_data_lines_out(dout), .host_data_lines_oe(),
    .busy_indicator(busy), .display_on(disp), .cursor_on(cur), .blink_on(blk),
    .bus_width(bus_w), .two_lines(two_l), .tall_font(tall), .shift_offset(shift));
  lcdd_host host (.clock(clock), .target_select(target_select), .read_mode(read_mode),
    .strobe(strobe), .host_data_lines_in(din), .host_data_lines_out(dout));
  // ************************************************************
  // clock, timeout and verdict
  // ************************************************************
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // about 40 operations of at most 600 clocks each fit well inside this
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic conclude();
    if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  // ************************************************************
  // shared helpers
  // ************************************************************
  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    while (busy === 1'b1 && n < 2000) begin
      @(posedge clock);
      n++;
    end
    `CHK("busy time", 1'b1, n <= lim)
  endtask : wait_idle
  task automatic op(input logic sel, input logic rd, input logic [7:0] d, input int lim);
    host.xfer(sel, rd, d, q);
    `CHK("busy raised", 1'b1, busy)
    wait_idle(lim);
  endtask : op
  task automatic pos(input logic [6:0] e);
    host.xfer(1'b0, 1'b1, 8'h00, q);
    `CHK("position", e, q[6:0])
  endtask : pos
  task automatic rdv(input logic [7:0] e);
    op(1'b1, 1'b1, 8'h00, 1000);
    `CHK("ram data", e, q)
  endtask : rdv
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic s_startup();
    repeat (3) @(posedge clock);
    host.access(1'b0, 1'b1, 8'h00, q);
    `CHK("startup busy", 1'b1, q[7])
    wait_idle(LONG_SIM + 8);
    `CHK("startup width", 4'b1000, {bus_w, two_l, tall, disp})
  endtask : s_startup
  task automatic s_flags();
    op(1'b0, 1'b0, 8'h3C, 1000);
    `CHK("function", 3'b111, {bus_w, two_l, tall})
    op(1'b0, 1'b0, 8'h30, 1000);
    `CHK("function", 3'b100, {bus_w, two_l, tall})
    op(1'b0, 1'b0, 8'h0F, 1000);
    `CHK("control", 3'b111, {disp, cur, blk})
    op(1'b0, 1'b0, 8'h0A, 1000);
    `CHK("control", 3'b010, {disp, cur, blk})
  endtask : s_flags
  task automatic s_text();
    op(1'b0, 1'b0, 8'h06, 1000);
    op(1'b0, 1'b0, 8'hC5, 1000);
    pos(7'h45);
    op(1'b1, 1'b0, 8'h41, 1000);
    op(1'b1, 1'b0, 8'h42, 1000);
    pos(7'h47);
    op(1'b0, 1'b0, 8'hC5, 1000);
    rdv(8'h41);
    pos(7'h46);
    op(1'b0, 1'b0, 8'h04, 1000);
    op(1'b1, 1'b0, 8'h43, 1000);
    pos(7'h45);
  endtask : s_text
  task automatic s_glyph();
    op(1'b0, 1'b0, 8'h06, 1000);
    op(1'b0, 1'b0, 8'h7F, 1000);
    pos(7'h3F);
    op(1'b1, 1'b0, 8'h1F, 1000);
    pos(7'h00);
    op(1'b0, 1'b0, 8'h7F, 1000);
    rdv(8'h1F);
  endtask : s_glyph
  task automatic s_shift();
    op(1'b0, 1'b0, 8'h1C, 1000);
    `CHK("offset", 7'h01, shift)
    op(1'b0, 1'b0, 8'h82, 1000);
    op(1'b0, 1'b0, 8'h10, 1000);
    pos(7'h01);
    `CHK("offset", 7'h01, shift)
    op(1'b0, 1'b0, 8'h07, 1000);
    op(1'b1, 1'b0, 8'h55, 1000);
    `CHK("offset", 7'h02, shift)
    op(1'b0, 1'b0, 8'h02, LONG_SIM + 8);
    `CHK("offset", 7'h00, shift)
    pos(7'h00);
    op(1'b0, 1'b0, 8'h06, 1000);
    op(1'b0, 1'b0, 8'hC5, 1000);
    rdv(8'h41);
  endtask : s_shift
  task automatic s_refuse();
    op(1'b0, 1'b0, 8'h80, 1000);
    host.access(1'b1, 1'b0, 8'h77, q);
    host.access(1'b1, 1'b0, 8'h66, q);
    wait_idle(1000);
    pos(7'h01);
    op(1'b0, 1'b0, 8'h80, 1000);
    rdv(8'h77);
  endtask : s_refuse
  task automatic s_clear();
    op(1'b0, 1'b0, 8'h01, LONG_SIM + 8);
    pos(7'h00);
    op(1'b0, 1'b0, 8'hC5, 1000);
    rdv(8'h20);
    op(1'b0, 1'b0, 8'hFF, 1000);
    rdv(8'h20);
  endtask : s_clear
  task automatic s_nibble();
    op(1'b0, 1'b0, 8'h28, 1000);
    `CHK("bus width", 1'b0, bus_w)
    host.nibble_mode = 1'b1;
    op(1'b0, 1'b0, 8'h80, 1000);
    op(1'b1, 1'b0, 8'h5A, 1000);
    pos(7'h01);
    op(1'b0, 1'b0, 8'h80, 1000);
    rdv(8'h5A);
  endtask : s_nibble
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    resetn = 1'b0;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    s_startup();
    s_flags();
    s_text();
    s_glyph();
    s_shift();
    s_refuse();
    s_clear();
    s_nibble();
    conclude();
  end
endmodule : tb_char_lcd_instruction_decoder
`default_nettype wire
